// ===== hw/pdt_pkg.sv
// Constants, encodings and types of the packet DRAM transaction core.
// Assumes one 25 MHz core clock; every bit window is one core clock cycle.
package pdt_pkg;

   // Bus geometry
   localparam int RQ_W = 12;
   localparam int DQ_W = 16;
   localparam int RQ_WINDOWS = 2;
   localparam int DQ_WINDOWS = 16;
   localparam int WINDOWS_PER_CLK = 8;

   // Organisation: 16, 8, 4 or 2 live data bits per word
   localparam int ORG_DATA_BITS = 16;
   // Per-pair rate of the speed grade, Mbit/s (2400, 3200 or 4000)
   localparam int PAIR_RATE_MBPS = 2400;

   // Banks and interleaving
   localparam int BANKS = 8;
   localparam int MAX_PENDING = 4;
   localparam int ROW_W = 2;
   localparam int COL_W = 2;
   localparam int ADDR_W = 3 + ROW_W + COL_W;
   localparam int WORD_W = 4;
   localparam int MEM_WORDS = 2 ** (ADDR_W + WORD_W);
   localparam int FIFO_DEPTH = 16;

   // Request-to-data delays in interface clocks, then in core cycles
   localparam int WRITE_DATA_DELAY_CLKS = 3;
   localparam int COL_ACCESS_DELAY_CLKS = 6;
   localparam int WRITE_DATA_DELAY_CYC = WRITE_DATA_DELAY_CLKS * WINDOWS_PER_CLK;
   localparam int COL_ACCESS_DELAY_CYC = COL_ACCESS_DELAY_CLKS * WINDOWS_PER_CLK;
   localparam logic [5:0] WR_TMR_LOAD = 6'(WRITE_DATA_DELAY_CYC - 2);
   localparam logic [5:0] RD_TMR_LOAD = 6'(COL_ACCESS_DELAY_CYC - 2);

   // Divider end count and last data word
   localparam logic [2:0] DIV_LAST = 3'(WINDOWS_PER_CLK - 1);
   localparam logic [3:0] WORD_LAST = 4'(DQ_WINDOWS - 1);
   localparam logic [15:0] DATA_MASK = 16'((17'h1 << ORG_DATA_BITS) - 17'h1);

   // Request packet field positions (24 bits, window 0 high)
   localparam int CMD_MSB = 23;
   localparam int CMD_LSB = 21;
   localparam int BANK_MSB = 20;
   localparam int BANK_LSB = 18;
   localparam int ROW_MSB = 17;
   localparam int ROW_LSB = 16;
   localparam int COL_MSB = 15;
   localparam int COL_LSB = 14;

   // Command codes
   localparam logic [2:0] CMD_NOP = 3'h0;
   localparam logic [2:0] CMD_ROW_OPEN = 3'h1;
   localparam logic [2:0] CMD_WRITE = 3'h2;
   localparam logic [2:0] CMD_READ = 3'h3;
   localparam logic [2:0] CMD_CLOSE = 3'h4;

   // Data phase, Gray along idle, write, read
   typedef enum logic [1:0] {
      PH_IDLE = 2'h0,
      PH_WRITE = 2'h1,
      PH_READ = 2'h3
   } pdt_phase_type;

endpackage : pdt_pkg

// ===== hw/pdt_core.sv
// Packet DRAM transaction core and its write-data FIFO.
// Assumes clk is the core clock recovered from the master clock pair,
// one cycle per bit window; pins come in unsynchronised.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module pdt_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk, // Core clock
   input wire logic rst_n, // Async reset, active low
   input wire logic in_valid, // Word offered
   output logic in_ready, // Room for a word
   input wire logic [WIDTH-1:0] in_data, // Word in
   output logic out_valid, // Word available
   input wire logic out_ready, // Drain takes it
   output logic [WIDTH-1:0] out_data // Oldest word
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wr_ptr;
      logic [AW:0] rd_ptr;
   } pdt_fifo_state_type;

   pdt_fifo_state_type st, next_st;
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW:0] fill;

   // Extra pointer bit tells full from empty
   assign fill = st.wr_ptr - st.rd_ptr;
   assign in_ready = (fill != (AW+1)'(DEPTH));
   assign out_valid = (fill != '0);
   assign out_data = store[st.rd_ptr[AW-1:0]];

   // Pointer advance
   always_comb begin
      next_st = st;
      if (in_valid && in_ready) begin
         next_st.wr_ptr = st.wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
         next_st.rd_ptr = st.rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Storage has no reset; empty flag guards it
   always_ff @(posedge clk) begin
      if (in_valid && in_ready) begin
         store[st.wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule : pdt_fifo

////////////////////////////////////////////////////////////////////////////
module pdt_core
   import pdt_pkg::*;
(
   input wire logic clk, // Core clock, 25 MHz
   input wire logic rst_n, // Async reset, active low
   input wire logic [RQ_W-1:0] request_bus, // Request pins
   input wire logic [DQ_W-1:0] data_pair_in, // Data receiver out
   output logic [DQ_W-1:0] data_pair_true_out, // Data true drive
   output logic [DQ_W-1:0] data_pair_comp_out, // Data comp drive
   output logic data_pair_oe, // High while driving
   output logic interface_tick, // Interface clock enable
   output logic write_overrun // Sticky FIFO overflow
);

   typedef struct packed {
      logic [RQ_W-1:0] rq_s1;
      logic [RQ_W-1:0] rq_s2;
      logic [DQ_W-1:0] dq_s1;
      logic [DQ_W-1:0] dq_s2;
      logic [2:0] div;
      logic tick;
      logic win1;
      logic [RQ_W-1:0] rq_hi;
      logic [BANKS-1:0] bank_open;
      logic [BANKS-1:0][ROW_W-1:0] open_row;
      logic [MAX_PENDING-1:0] slot_v;
      logic [MAX_PENDING-1:0] slot_wr;
      logic [MAX_PENDING-1:0][ADDR_W-1:0] slot_addr;
      logic [MAX_PENDING-1:0][5:0] slot_tmr;
      pdt_phase_type phase;
      logic [ADDR_W-1:0] cur_addr;
      logic [WORD_W-1:0] word;
      logic [DQ_W-1:0] dq_out;
      logic [DQ_W-1:0] dq_comp;
      logic dq_oe;
      logic overrun;
   } pdt_state_type;

   pdt_state_type st, next_st;
   logic [DQ_W-1:0] mem [MEM_WORDS];
   logic [DQ_W-1:0] mem_rd;
   logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [ADDR_W+WORD_W+DQ_W-1:0] fifo_in_data, fifo_out_data;
   logic col_acc, launch;

   // Array index of one word of a column packet
   function automatic logic [ADDR_W+WORD_W-1:0] pdt_index(
      input logic [ADDR_W-1:0] addr, input logic [WORD_W-1:0] word);
      pdt_index = {addr, word};
   endfunction : pdt_index

   assign mem_rd = mem[pdt_index(st.cur_addr, st.word)];
   // Write words queue behind reads on the single array port
   assign fifo_in_data = {pdt_index(st.cur_addr, st.word),
                          st.dq_s2 & DATA_MASK};
   assign fifo_out_ready = (st.phase != PH_READ);

   pdt_fifo #(.WIDTH(ADDR_W+WORD_W+DQ_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(st.phase == PH_WRITE),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // Sense amp array write port, drained from the FIFO
   always_ff @(posedge clk) begin
      if (fifo_out_valid && fifo_out_ready) begin
         mem[fifo_out_data[ADDR_W+WORD_W+DQ_W-1:DQ_W]] <=
            fifo_out_data[DQ_W-1:0];
      end
   end

   // Next state of the whole core
   always_comb begin
      logic [RQ_W*RQ_WINDOWS-1:0] pkt;
      logic [2:0] cmd, bank;
      logic found;
      int unsigned sel;
      pkt = {st.rq_hi, st.rq_s2};
      cmd = pkt[CMD_MSB:CMD_LSB];
      bank = pkt[BANK_MSB:BANK_LSB];
      found = 1'b0;
      sel = 0;
      col_acc = 1'b0;
      launch = 1'b0;
      next_st = st;
      // Two-stage pin synchronisers
      next_st.rq_s1 = request_bus;
      next_st.rq_s2 = st.rq_s1;
      next_st.dq_s1 = data_pair_in;
      next_st.dq_s2 = st.dq_s1;
      // One interface clock per eight bit windows
      next_st.div = st.div + 3'h1;
      next_st.tick = (next_st.div == DIV_LAST);
      // Window 0 at the interface edge, window 1 next cycle
      next_st.win1 = (st.div == DIV_LAST);
      if (st.div == DIV_LAST) begin
         next_st.rq_hi = st.rq_s2;
      end
      // Countdown of queued column packets
      for (int i = 0; i < MAX_PENDING; i++) begin
         if (st.slot_v[i] && st.slot_tmr[i] != '0) begin
            next_st.slot_tmr[i] = st.slot_tmr[i] - 6'h1;
         end
      end
      // Decode a complete request packet
      if (st.win1) begin
         if (cmd == CMD_ROW_OPEN) begin
            next_st.bank_open[bank] = 1'b1;
            next_st.open_row[bank] = pkt[ROW_MSB:ROW_LSB];
         end else if (cmd == CMD_CLOSE) begin
            next_st.bank_open[bank] = 1'b0;
         end else if ((cmd == CMD_WRITE || cmd == CMD_READ) &&
                      st.bank_open[bank]) begin
            // Lowest free slot; a fifth command is dropped
            for (int i = MAX_PENDING - 1; i >= 0; i--) begin
               if (!st.slot_v[i]) begin
                  found = 1'b1;
                  sel = i;
               end
            end
            if (found) begin
               col_acc = 1'b1;
               next_st.slot_v[sel] = 1'b1;
               next_st.slot_wr[sel] = (cmd == CMD_WRITE);
               next_st.slot_addr[sel] = {bank, st.open_row[bank],
                                         pkt[COL_MSB:COL_LSB]};
               next_st.slot_tmr[sel] = (cmd == CMD_WRITE) ?
                                       WR_TMR_LOAD : RD_TMR_LOAD;
            end
         end
      end
      // Start the data packet of an expired slot
      found = 1'b0;
      sel = 0;
      for (int i = MAX_PENDING - 1; i >= 0; i--) begin
         if (st.slot_v[i] && st.slot_tmr[i] == '0) begin
            found = 1'b1;
            sel = i;
         end
      end
      if (st.phase == PH_IDLE && found) begin
         launch = 1'b1;
         next_st.slot_v[sel] = 1'b0;
         next_st.phase = st.slot_wr[sel] ? PH_WRITE : PH_READ;
         next_st.cur_addr = st.slot_addr[sel];
         next_st.word = '0;
      end
      // Sixteen windows per data packet
      next_st.dq_oe = (st.phase == PH_READ);
      if (st.phase != PH_IDLE) begin
         next_st.word = st.word + 4'h1;
         if (st.word == WORD_LAST) begin
            next_st.phase = PH_IDLE;
         end
      end
      if (st.phase == PH_READ) begin
         next_st.dq_out = mem_rd & DATA_MASK;
         next_st.dq_comp = ~(mem_rd & DATA_MASK);
      end else begin
         next_st.dq_out = '0;
         next_st.dq_comp = '0;
      end
      // Lost write words are only reported, never retried
      if (st.phase == PH_WRITE && !fifo_in_ready) begin
         next_st.overrun = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state; comp lane has its own flops
   assign data_pair_true_out = st.dq_out;
   assign data_pair_comp_out = st.dq_comp;
   assign data_pair_oe = st.dq_oe;
   assign interface_tick = st.tick;
   assign write_overrun = st.overrun;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_quiet7;
      !st.tick [*7];
   endsequence

   property p_tick;
      @(posedge clk) disable iff (!rst_n)
      st.tick |=> s_quiet7 ##1 st.tick;
   endproperty
   a_tick: assert property (p_tick) else $error("tick spacing");

   property p_two_windows;
      @(posedge clk) disable iff (!rst_n)
      (st.div == DIV_LAST) |=> st.win1 ##1 !st.win1;
   endproperty
   a_two_windows: assert property (p_two_windows)
      else $error("request not two windows");

   property p_open;
      @(posedge clk) disable iff (!rst_n)
      (st.win1 && st.rq_hi[CMD_MSB-RQ_W:CMD_LSB-RQ_W] == CMD_ROW_OPEN) |=>
         st.bank_open[$past(st.rq_hi[BANK_MSB-RQ_W:BANK_LSB-RQ_W])];
   endproperty
   a_open: assert property (p_open) else $error("row not opened");

   sequence s_wr_packet;
      ##15 (st.word == WORD_LAST) ##1 (st.phase != PH_WRITE);
   endsequence

   property p_wr_len;
      @(posedge clk) disable iff (!rst_n)
      $rose(st.phase == PH_WRITE) |-> s_wr_packet;
   endproperty
   a_wr_len: assert property (p_wr_len) else $error("write length");

   property p_rd_drive;
      @(posedge clk) disable iff (!rst_n)
      $rose(st.phase == PH_READ) |=> data_pair_oe [*8];
   endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("read no drive");

   property p_wr_push;
      @(posedge clk) disable iff (!rst_n)
      (st.phase == PH_WRITE && fifo_in_ready) |=> !st.overrun ||
         $past(st.overrun);
   endproperty
   a_wr_push: assert property (p_wr_push) else $error("false overrun");

   property p_launch;
      @(posedge clk) disable iff (!rst_n)
      col_acc |-> ##[1:200] launch;
   endproperty
   a_launch: assert property (p_launch) else $error("slot never ran");

   property p_comp;
      @(posedge clk) disable iff (!rst_n)
      data_pair_oe |-> (data_pair_comp_out == ~data_pair_true_out);
   endproperty
   a_comp: assert property (p_comp) else $error("pair not complement");

endmodule : pdt_core

`default_nettype wire

// ===== verif/pdt_ctrl_model.sv
// Controller model facing the core: request packets and write data.
// Assumes the core clock is also the bench clock; drives on falling edge.
`timescale 1ns/1ps
`default_nettype none

module pdt_ctrl_model
   import pdt_pkg::*;
(
   input wire logic clk, // Core clock
   input wire logic interface_tick, // Interface clock mark
   output logic [RQ_W-1:0] request_bus, // Request pins
   output logic [DQ_W-1:0] data_pair_in // Data pins into device
);
   logic drv;

   // Idle request bus is a no-op packet
   initial begin
      request_bus = '0;
      data_pair_in = '0;
      drv = 1'b0;
   end

   // Released data lines flip each cycle so stale words never match
   always @(negedge clk) begin
      if (!drv) begin
         data_pair_in <= ~data_pair_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One packet, two windows, placed so window 0 meets the tick edge
   task automatic send(input logic [2:0] cmd, input logic [2:0] bank,
      input logic [1:0] row, input logic [1:0] col, output bit ok);
      logic [23:0] pkt;
      int i;
      pkt = {cmd, bank, row, col, 14'h0};
      ok = 1'b0;
      for (i = 0; i < 20 && !ok; i++) begin
         @(negedge clk);
         ok = (interface_tick === 1'b1);
      end
      repeat (6) @(negedge clk);
      request_bus <= pkt[23:12];
      @(negedge clk);
      request_bus <= pkt[11:0];
      @(negedge clk);
      request_bus <= '0;
   endtask : send

   // Write data packet, word 0 first, after the write data delay
   task automatic put_data(input logic [DQ_W-1:0] w [16]);
      drv = 1'b1;
      repeat (WRITE_DATA_DELAY_CYC - 2) @(negedge clk);
      foreach (w[k]) begin
         @(negedge clk);
         data_pair_in <= w[k];
      end
      @(negedge clk);
      drv = 1'b0;
   endtask : put_data
endmodule : pdt_ctrl_model

`default_nettype wire

// ===== verif/pdt_core_bench.sv
// Self-checking bench for the transaction core and its write FIFO.
// Assumes pdt_ctrl_model as the controller; fixed seed for repeatability.
`timescale 1ns/1ps
`default_nettype none

module pdt_core_bench
   import pdt_pkg::*;
;
   logic clk, rst_n, oe, tick, ovr;
   logic [RQ_W-1:0] rq;
   logic [DQ_W-1:0] dq_in, dq_t, dq_c;
   logic [DQ_W-1:0] mem [int];
   int num_errors, tests_run, seed, i, j, n;
   logic [2:0] bk [4];
   logic [1:0] rw [4];
   logic [1:0] co;

   pdt_core uut (.clk(clk), .rst_n(rst_n), .request_bus(rq),
      .data_pair_in(dq_in), .data_pair_true_out(dq_t),
      .data_pair_comp_out(dq_c), .data_pair_oe(oe),
      .interface_tick(tick), .write_overrun(ovr));
   pdt_ctrl_model m (.clk(clk), .interface_tick(tick), .request_bus(rq),
      .data_pair_in(dq_in));

   // Fixed 40 ns core clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [DQ_W-1:0] seen, exp, input string s);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s", $time, s);
      end
   endtask : check

   // Expected word k of the column packet at address a
   function automatic logic [DQ_W-1:0] exp_word(input int a, input int k);
      return mem[a * 16 + k];
   endfunction : exp_word

   task automatic results;
      $display("errors %0d, checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   // Drive slot is fixed: nothing before it, sixteen words, then release
   task automatic rd_check(input int a, input bit live);
      logic [DQ_W-1:0] e;
      for (int t = 1; t <= 66; t++) begin
         @(negedge clk);
         if (t < 50 || t == 66 || !live) begin
            check(oe, 0, "drive out of slot");
         end else begin
            e = exp_word(a, t - 50);
            check(oe, 1, "drive missing");
            check(dq_t, e, "read word");
            check(dq_c, 16'(~e), "comp lane");
         end
      end
   endtask : rd_check

   // One request, with its data packet where the command has one
   task automatic xfer(input logic [2:0] c, b, input logic [1:0] r, cl,
      input bit live);
      logic [DQ_W-1:0] w [16];
      int a;
      bit ok;
      a = int'({b, r, cl});
      m.send(c, b, r, cl, ok);
      if (!ok) begin
         check(0, 1, "tick lost");
         results();
      end
      if (c == CMD_WRITE) begin
         foreach (w[k]) begin
            w[k] = DQ_W'($random(seed)) & DATA_MASK;
            mem[a * 16 + k] = w[k];
         end
         m.put_data(w);
      end else begin
         rd_check(a, live && c == CMD_READ);
      end
   endtask : xfer

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed = 32'h263d;
      rst_n = 1'b0;
      repeat (10) @(negedge clk);
      check(dq_t | dq_c, 0, "data idle in reset");
      check({oe, tick, ovr}, 0, "flags in reset");
      rst_n = 1'b1;
      // Interface clock mark every eight cycles
      for (i = 1; i <= 24; i++) begin
         @(negedge clk);
         check(tick, i % 8 == 7, "tick phase");
      end
      // Four banks open at once, the deepest interleave depth
      for (j = 0; j < 4; j++) begin
         bk[j] = 3'(j * 2 + ($random(seed) & 1));
         rw[j] = 2'($random(seed));
         xfer(CMD_ROW_OPEN, bk[j], rw[j], 2'h0, 1'b0);
      end
      // Random writes and read-backs across them, repeats overwrite
      for (j = 0; j < 8; j++) begin
         n = $random(seed) & 3;
         co = 2'($random(seed));
         xfer(CMD_WRITE, bk[n], rw[n], co, 1'b1);
         check(ovr, 0, "write fifo room");
         xfer(CMD_READ, bk[n], rw[n], co, 1'b1);
      end
      // Closed bank, unknown code and no-op produce no data
      xfer(CMD_CLOSE, bk[n], rw[n], co, 1'b0);
      xfer(CMD_READ, bk[n], rw[n], co, 1'b0);
      xfer(3'h7, bk[0], rw[0], co, 1'b0);
      xfer(CMD_NOP, bk[0], rw[0], co, 1'b0);
      check(ovr, 0, "no overrun");
      // Same column written twice through the FIFO: later packet wins
      xfer(CMD_ROW_OPEN, bk[0], rw[0], 2'h0, 1'b0);
      xfer(CMD_WRITE, bk[0], rw[0], 2'h3, 1'b1);
      check(ovr, 0, "fifo room first");
      xfer(CMD_WRITE, bk[0], rw[0], 2'h3, 1'b1);
      check(ovr, 0, "fifo room second");
      xfer(CMD_READ, bk[0], rw[0], 2'h3, 1'b1);
      // Reset mid-run: outputs clear, divider restarts, banks close
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      check(dq_t | dq_c, 0, "data idle in second reset");
      check({oe, tick, ovr}, 0, "flags in second reset");
      rst_n = 1'b1;
      for (i = 1; i <= 8; i++) begin
         @(negedge clk);
         check(tick, i == 7, "tick phase after reset");
      end
      xfer(CMD_READ, bk[0], rw[0], 2'h3, 1'b0);
      results();
   end
endmodule : pdt_core_bench

`default_nettype wire
